// file: rtl/fesr_ctrl.sv
// erase sequencer with program/erase suspend and resume
`timescale 1ns/1ps
`include "fesr_regs.svh"

// Operation
// (RULE_01) erase returns bits from 0 to the erased value 1.
// (RULE_02) erase without write-enable latch set is silently ignored, no flags.
// (RULE_03) controller holds chip select low to the last byte, then raises it.
// (RULE_04) without chip select rising nothing runs, no flags, latch stays.
// (RULE_05) erase of a protected region is refused; latch stays; flags 1, 5 set.
// (RULE_06) while erasing, ready bit reads 0 and busy bit 1; busy clears at end.
// (RULE_07) write-enable latch clears at end of every erase, pass or fail.
// (RULE_08) erase over its time limit clears latch and sets erase-error flag.
// (RULE_09) erase time is self-timed, chosen by subsector, sector or chip command.
// (RULE_10) 52h and 20h erase a subsector, D8h a sector; any inner address.
// (RULE_11) C7h and 60h erase everything; refused like protection if any lock.
// (RULE_12) address bits are taken on rising serial clock edges. In octal ddr the link takes every second address byte on the falling edge.
// (RULE_13) octal ddr moves two bytes per clock; address is always four bytes.
// (RULE_14) suspend 75h sets flag 2 for program, flag 6 for erase.
// (RULE_15) flag 7 rises after suspend latency; controller then sees suspension.
// (RULE_16) when less work remains than the latency, finish and clear flag 2/6.
// (RULE_17) flag status resets to 80h; no suspension survives power up.
// (RULE_18) one nesting level: erase, then program; resumes unwind newest first.
// (RULE_19) reads of a suspended sector are marked indeterminate.
// (RULE_20) program into an erase-suspended sector is ignored, flag 4 set.
// (RULE_21) resumed erase does not recheck lock bits.
// (RULE_22) suspend and resume are bare opcodes ended by chip select high.
// (RULE_23) resume 7Ah sets busy and clears ready; ignored when not suspended.
// (RULE_24) running erase ignores new program or erase, only suspend accepted.
module fesr_ctrl #(
  parameter int unsigned SSE_CYC = `FESR_SUBSECTOR_ERASE_TIME_US * `FESR_MCLK_MHZ,
  parameter int unsigned SE_CYC = `FESR_SECTOR_ERASE_TIME_US * `FESR_MCLK_MHZ,
  parameter int unsigned BE_CYC = `FESR_WHOLE_ARRAY_ERASE_TIME_US * `FESR_MCLK_MHZ,
  parameter int unsigned PP_CYC = `FESR_PAGE_WRITE_TIME_US * `FESR_MCLK_MHZ
) (
  // core clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // serial bus
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [7:0] i_octal_data_lines,
  input wire logic i_octal_ddr,
  // array side
  input wire logic [63:0] i_sector_lock,
  input wire logic i_erase_verify_fail,
  input wire logic [5:0] i_read_sector,
  // status
  output logic o_wel,
  output logic o_wip,
  output logic [7:0] o_flag_status,
  // array control
  output logic o_erase_active,
  output logic [22:0] o_erase_base,
  output fesr_pkg::fesr_kind_t o_erase_kind,
  output logic o_program_active,
  output logic [22:0] o_program_addr,
  output logic o_read_indeterminate
);
  import fesr_pkg::*;

  fesr_state_t state_r;
  fesr_state_t state_nxt;
  fesr_kind_t kind_nxt;
  logic cs_s;
  logic cs_d_r;
  logic [7:0] lk_op;
  logic [31:0] lk_addr;
  logic [7:0] lk_nb;
  logic lk_ddr;
  logic cmd_v_r;
  logic [7:0] cmd_op_r;
  logic [22:0] cmd_addr_r;
  logic [7:0] cmd_nb_r;
  logic cmd_ddr_r;
  logic [7:0] need;
  logic is_erase;
  logic is_chip;
  logic is_pgm;
  logic go;
  logic [5:0] cmd_sec;
  logic [22:0] base_nxt;
  logic [31:0] ers_left_r;
  logic [31:0] pgm_left_r;
  logic [31:0] susp_cnt_r;
  logic ers_held_r;
  logic wel_r;
  logic wip_r;
  logic [7:0] fsr_r;
  logic ev_wren;
  logic ev_wrdi;
  logic ev_clfsr;
  logic ev_ers_req;
  logic ev_prot;
  logic ev_ers_start;
  logic ev_pgm_req;
  logic ev_pgm_conf;
  logic ev_pgm_start;
  logic ev_susp_e;
  logic ev_susp_p;
  logic ev_res_e;
  logic ev_res_p;
  logic ev_ers_done;
  logic ev_pgm_done;
  logic ev_sw_done;
  logic long_e;
  logic long_p;
  logic quiet;

  // frame capture runs on the serial clock
  fesr_link u_link (
    .i_sclk(i_sclk),
    .i_reset_n(i_reset_n),
    .i_cs_n(i_cs_n),
    .i_octal_data_lines(i_octal_data_lines),
    .i_octal_ddr(i_octal_ddr),
    .o_opcode(lk_op),
    .o_addr(lk_addr),
    .o_nbytes(lk_nb),
    .o_ddr(lk_ddr)
  );

  fesr_sync #(.RST(1'b1)) u_cs_sync (
    .i_clk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_d(i_cs_n),
    .o_q(cs_s)
  );

  // link values are static once chip select is high, so take them then
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_d_r <= 1'b1;
      cmd_v_r <= 1'b0;
      cmd_op_r <= 8'h00;
      cmd_addr_r <= 23'h000000;
      cmd_nb_r <= 8'h00;
      cmd_ddr_r <= 1'b0;
    end else begin
      cs_d_r <= cs_s;
      cmd_v_r <= cs_s & ~cs_d_r; // [RULE_03] [RULE_04] [RULE_22]
      if (cs_s & ~cs_d_r) begin
        cmd_op_r <= lk_op;
        cmd_addr_r <= lk_addr[22:0];
        cmd_nb_r <= lk_nb;
        cmd_ddr_r <= lk_ddr;
      end
    end
  end

  // decode
  assign is_chip = cmd_op_r == `FESR_OP_CE1 || cmd_op_r == `FESR_OP_CE2;
  assign is_erase = is_chip || cmd_op_r == `FESR_OP_SSE4 ||
                    cmd_op_r == `FESR_OP_SSE32 || cmd_op_r == `FESR_OP_SE;
  assign is_pgm = cmd_op_r == `FESR_OP_PP1 || cmd_op_r == `FESR_OP_PP2 ||
                  cmd_op_r == `FESR_OP_PP3 || cmd_op_r == `FESR_OP_PP4 ||
                  cmd_op_r == `FESR_OP_PP5 || cmd_op_r == `FESR_OP_PP6;
  assign cmd_sec = cmd_addr_r[`FESR_SEC_MSB:`FESR_SEC_LSB];

  // whole bytes only; a short or ragged frame never runs [RULE_03] [RULE_13]
  always_comb begin
    need = cmd_ddr_r ? `FESR_CMD_DDR : `FESR_CMD_SDR;
    if (is_pgm || (is_erase && !is_chip)) begin
      need = need + `FESR_ADDR_LEN;
    end
    if (is_pgm) begin
      need = need + (cmd_ddr_r ? 8'h02 : 8'h01);
    end
    go = cmd_v_r && (is_pgm ? cmd_nb_r >= need : cmd_nb_r == need);
  end

  // erased region, any address inside selects it [RULE_10] [RULE_11]
  always_comb begin
    unique case (cmd_op_r)
      `FESR_OP_SSE4: begin
        kind_nxt = K_SUB4;
        base_nxt = cmd_addr_r & `FESR_MASK_SUB4;
      end
      `FESR_OP_SSE32: begin
        kind_nxt = K_SUB32;
        base_nxt = cmd_addr_r & `FESR_MASK_SUB32;
      end
      `FESR_OP_SE: begin
        kind_nxt = K_SECT;
        base_nxt = cmd_addr_r & `FESR_MASK_SECT;
      end
      default: begin
        kind_nxt = K_CHIP;
        base_nxt = 23'h000000;
      end
    endcase
  end

  assign quiet = state_r == S_IDLE || state_r == S_ERS_SUS || state_r == S_PGM_SUS;
  assign ev_wren = go && quiet && cmd_op_r == `FESR_OP_WREN;
  assign ev_wrdi = go && quiet && cmd_op_r == `FESR_OP_WRDI;
  assign ev_clfsr = go && quiet && cmd_op_r == `FESR_OP_CLFSR;
  // busy states take nothing but suspend [RULE_24]; latch gates erase [RULE_02]
  assign ev_ers_req = go && is_erase && state_r == S_IDLE && wel_r;
  assign ev_prot = ev_ers_req && (is_chip ? |i_sector_lock : i_sector_lock[cmd_sec]); // [RULE_05] [RULE_11]
  assign ev_ers_start = ev_ers_req && !ev_prot;
  assign ev_pgm_req = go && is_pgm && wel_r && (state_r == S_IDLE || state_r == S_ERS_SUS);
  assign ev_pgm_conf = ev_pgm_req && state_r == S_ERS_SUS &&
                       (o_erase_kind == K_CHIP || o_erase_base[`FESR_SEC_MSB:`FESR_SEC_LSB] == cmd_sec); // [RULE_20]
  assign ev_pgm_start = ev_pgm_req && !ev_pgm_conf;
  assign ev_susp_e = go && cmd_op_r == `FESR_OP_SUSP && state_r == S_ERS; // [RULE_14]
  assign ev_susp_p = go && cmd_op_r == `FESR_OP_SUSP && state_r == S_PGM; // [RULE_14]
  assign ev_res_e = go && cmd_op_r == `FESR_OP_RESM && state_r == S_ERS_SUS; // [RULE_23]
  assign ev_res_p = go && cmd_op_r == `FESR_OP_RESM && state_r == S_PGM_SUS; // [RULE_18] [RULE_23]
  assign ev_ers_done = state_r == S_ERS && ers_left_r == 32'h00000001;
  assign ev_pgm_done = state_r == S_PGM && pgm_left_r == 32'h00000001;
  assign ev_sw_done = (state_r == S_ERS_SW || state_r == S_PGM_SW) && susp_cnt_r == 32'h00000001;
  // near the end a suspend is not worth its latency [RULE_16]
  assign long_e = ers_left_r > `FESR_SUSPEND_LATENCY_CYC;
  assign long_p = pgm_left_r > `FESR_SUSPEND_LATENCY_CYC;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (ev_ers_start) begin
          state_nxt = S_ERS;
        end else if (ev_pgm_start) begin
          state_nxt = S_PGM;
        end
      end
      S_ERS: begin
        if (ev_ers_done) begin
          state_nxt = S_IDLE;
        end else if (ev_susp_e && long_e) begin
          state_nxt = S_ERS_SW;
        end
      end
      S_ERS_SW: begin
        if (ev_sw_done) begin
          state_nxt = S_ERS_SUS;
        end
      end
      S_ERS_SUS: begin
        if (ev_res_e) begin
          state_nxt = S_ERS; // [RULE_21]
        end else if (ev_pgm_start) begin
          state_nxt = S_PGM;
        end
      end
      S_PGM: begin
        if (ev_pgm_done) begin
          state_nxt = ers_held_r ? S_ERS_SUS : S_IDLE; // [RULE_18]
        end else if (ev_susp_p && long_p) begin
          state_nxt = S_PGM_SW;
        end
      end
      S_PGM_SW: begin
        if (ev_sw_done) begin
          state_nxt = S_PGM_SUS;
        end
      end
      S_PGM_SUS: begin
        if (ev_res_p) begin
          state_nxt = S_PGM;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // nothing suspended after reset [RULE_17]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= S_IDLE;
      ers_held_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (ev_pgm_start) begin
        ers_held_r <= state_r == S_ERS_SUS; // [RULE_18]
      end else if (ev_pgm_done) begin
        ers_held_r <= 1'b0;
      end
    end
  end

  // self-timed counters; the command picks the erase time [RULE_09]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ers_left_r <= 32'h00000000;
      pgm_left_r <= 32'h00000000;
      susp_cnt_r <= 32'h00000000;
    end else begin
      if (ev_ers_start) begin
        ers_left_r <= is_chip ? BE_CYC : (cmd_op_r == `FESR_OP_SE ? SE_CYC : SSE_CYC); // [RULE_09]
      end else if (state_r == S_ERS) begin
        ers_left_r <= ers_left_r - 32'h00000001;
      end
      if (ev_pgm_start) begin
        pgm_left_r <= PP_CYC;
      end else if (state_r == S_PGM) begin
        pgm_left_r <= pgm_left_r - 32'h00000001;
      end
      if ((ev_susp_e && long_e) || (ev_susp_p && long_p)) begin
        susp_cnt_r <= `FESR_SUSPEND_LATENCY_CYC; // [RULE_15]
      end else if (state_r == S_ERS_SW || state_r == S_PGM_SW) begin
        susp_cnt_r <= susp_cnt_r - 32'h00000001;
      end
    end
  end

  // write-enable latch: refusals leave it alone [RULE_05] [RULE_20]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wel_r <= 1'b0;
    end else if (ev_ers_done || ev_pgm_done || ev_wrdi) begin
      wel_r <= 1'b0; // [RULE_07] [RULE_08]
    end else if (ev_wren) begin
      wel_r <= 1'b1;
    end
  end

  // busy bit [RULE_06] [RULE_23]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wip_r <= 1'b0;
    end else if (ev_ers_start || ev_pgm_start || ev_res_e || ev_res_p) begin
      wip_r <= 1'b1;
    end else if (ev_ers_done || ev_pgm_done || ev_sw_done) begin
      wip_r <= 1'b0;
    end
  end

  // flag status; error flags clear first so a same-cycle set wins
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fsr_r <= `FESR_FSR_RESET; // [RULE_17]
    end else begin
      if (ev_clfsr) begin
        fsr_r[`FESR_FSR_EERR] <= 1'b0;
        fsr_r[`FESR_FSR_PERR] <= 1'b0;
        fsr_r[`FESR_FSR_PROT] <= 1'b0;
      end
      if (ev_ers_start || ev_pgm_start || ev_res_e || ev_res_p) begin
        fsr_r[`FESR_FSR_READY] <= 1'b0; // [RULE_06] [RULE_23]
      end else if (ev_ers_done || ev_pgm_done || ev_sw_done) begin
        fsr_r[`FESR_FSR_READY] <= 1'b1; // [RULE_15]
      end
      if (ev_susp_e && !ev_ers_done) begin
        fsr_r[`FESR_FSR_ESUS] <= 1'b1; // [RULE_14]
      end else if (ev_res_e || ev_ers_done) begin
        fsr_r[`FESR_FSR_ESUS] <= 1'b0; // [RULE_16]
      end
      if (ev_susp_p && !ev_pgm_done) begin
        fsr_r[`FESR_FSR_PSUS] <= 1'b1; // [RULE_14]
      end else if (ev_res_p || ev_pgm_done) begin
        fsr_r[`FESR_FSR_PSUS] <= 1'b0; // [RULE_16]
      end
      if (ev_prot || (ev_ers_done && i_erase_verify_fail)) begin
        fsr_r[`FESR_FSR_EERR] <= 1'b1; // [RULE_05] [RULE_08]
      end
      if (ev_prot) begin
        fsr_r[`FESR_FSR_PROT] <= 1'b1; // [RULE_05] [RULE_11]
      end
      if (ev_pgm_conf) begin
        fsr_r[`FESR_FSR_PERR] <= 1'b1; // [RULE_20]
      end
    end
  end

  // array control; erase drives the region to all ones [RULE_01] [RULE_10]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_erase_active <= 1'b0;
      o_erase_base <= 23'h000000;
      o_erase_kind <= K_SUB4;
      o_program_active <= 1'b0;
      o_program_addr <= 23'h000000;
    end else begin
      o_erase_active <= state_nxt == S_ERS; // [RULE_01]
      o_program_active <= state_nxt == S_PGM;
      if (ev_ers_start) begin
        o_erase_base <= base_nxt;
        o_erase_kind <= kind_nxt;
      end
      if (ev_pgm_start) begin
        o_program_addr <= cmd_addr_r;
      end
    end
  end

  // a suspended sector gives no trustworthy read data [RULE_19]
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_read_indeterminate <= 1'b0;
    end else begin
      o_read_indeterminate <=
        ((ers_held_r || state_r == S_ERS_SUS) &&
         (o_erase_kind == K_CHIP || o_erase_base[`FESR_SEC_MSB:`FESR_SEC_LSB] == i_read_sector)) ||
        (state_r == S_PGM_SUS && o_program_addr[`FESR_SEC_MSB:`FESR_SEC_LSB] == i_read_sector);
    end
  end

  assign o_wel = wel_r;
  assign o_wip = wip_r;
  assign o_flag_status = fsr_r;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  property p_wel_gate;
    go && is_erase && !wel_r |=> state_r == $past(state_r) && $stable(fsr_r);
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("erase ran without latch"); // [RULE_02]

  property p_protect;
    ev_prot |=> fsr_r[`FESR_FSR_PROT] && fsr_r[`FESR_FSR_EERR] && wel_r && state_r == S_IDLE;
  endproperty
  a_protect: assert property (p_protect) else $error("protected erase not refused"); // [RULE_05]

  property p_busy;
    state_r == S_ERS |-> !fsr_r[`FESR_FSR_READY] && wip_r && o_erase_active;
  endproperty
  a_busy: assert property (p_busy) else $error("erase status wrong"); // [RULE_06]

  property p_end_wel;
    ev_ers_done |=> !wel_r && !wip_r && fsr_r[`FESR_FSR_READY] && !fsr_r[`FESR_FSR_ESUS];
  endproperty
  a_end_wel: assert property (p_end_wel) else $error("erase end status wrong"); // [RULE_07]

  property p_timeout;
    ev_ers_done && i_erase_verify_fail |=> fsr_r[`FESR_FSR_EERR] && !wel_r;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged"); // [RULE_08]

  property p_susp;
    ev_susp_e && long_e |=> fsr_r[`FESR_FSR_ESUS] && !fsr_r[`FESR_FSR_READY] ##1 state_r == S_ERS_SW;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not taken"); // [RULE_14]

  property p_latency;
    state_r == S_ERS_SW && susp_cnt_r == 32'h00000001 |=> state_r == S_ERS_SUS && fsr_r[`FESR_FSR_READY];
  endproperty
  a_latency: assert property (p_latency) else $error("suspend latency end wrong"); // [RULE_15]

  property p_resume_idle;
    go && cmd_op_r == `FESR_OP_RESM && state_r == S_IDLE |=> state_r == S_IDLE && !wip_r;
  endproperty
  a_resume_idle: assert property (p_resume_idle) else $error("resume acted when idle"); // [RULE_23]

  property p_conflict;
    ev_pgm_conf |=> fsr_r[`FESR_FSR_PERR] && state_r == S_ERS_SUS && wel_r == $past(wel_r);
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflicting program ran"); // [RULE_20]

  property p_busy_reject;
    state_r == S_ERS && go && (is_erase || is_pgm) && !ev_ers_done |=> $stable(fsr_r) && state_r != S_PGM;
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("busy erase took command"); // [RULE_24]

  c_erase: cover property (ev_ers_done && !i_erase_verify_fail);
  c_suspend: cover property (state_r == S_ERS_SUS);
  c_nested: cover property (state_r == S_PGM_SUS && ers_held_r);
  c_prot: cover property (ev_prot);
endmodule : fesr_ctrl

// file: rtl/fesr_regs.svh
// constants of the erase, suspend and resume sequencer
`ifndef FESR_REGS_SVH
`define FESR_REGS_SVH

`define FESR_MCLK_MHZ 50

`define FESR_OP_WREN 8'h06
`define FESR_OP_WRDI 8'h04
`define FESR_OP_CLFSR 8'h50
`define FESR_OP_SSE4 8'h20
`define FESR_OP_SSE32 8'h52
`define FESR_OP_SE 8'hD8
`define FESR_OP_CE1 8'hC7
`define FESR_OP_CE2 8'h60
`define FESR_OP_SUSP 8'h75
`define FESR_OP_RESM 8'h7A
`define FESR_OP_PP1 8'h02
`define FESR_OP_PP2 8'h12
`define FESR_OP_PP3 8'h82
`define FESR_OP_PP4 8'h84
`define FESR_OP_PP5 8'hC2
`define FESR_OP_PP6 8'h8E

`define FESR_FSR_RESET 8'h80
`define FESR_FSR_READY 7
`define FESR_FSR_ESUS 6
`define FESR_FSR_EERR 5
`define FESR_FSR_PERR 4
`define FESR_FSR_PSUS 2
`define FESR_FSR_PROT 1

`define FESR_SEC_MSB 22
`define FESR_SEC_LSB 17
`define FESR_MASK_SUB4 23'h7FF000
`define FESR_MASK_SUB32 23'h7F8000
`define FESR_MASK_SECT 23'h7E0000

`define FESR_CMD_SDR 8'h01
`define FESR_CMD_DDR 8'h02
`define FESR_ADDR_LEN 8'h04

`define FESR_SUBSECTOR_ERASE_TIME_US 400
`define FESR_SECTOR_ERASE_TIME_US 1000
`define FESR_WHOLE_ARRAY_ERASE_TIME_US 100000
`define FESR_PAGE_WRITE_TIME_US 200
`define FESR_SUSPEND_LATENCY_US 30
`define FESR_SUSPEND_LATENCY_CYC (`FESR_SUSPEND_LATENCY_US * `FESR_MCLK_MHZ)

`endif

// file: rtl/fesr_pkg.sv
// types of the erase, suspend and resume sequencer
package fesr_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ERS = 3'b001,
    S_ERS_SW = 3'b010,
    S_ERS_SUS = 3'b011,
    S_PGM = 3'b100,
    S_PGM_SW = 3'b101,
    S_PGM_SUS = 3'b110
  } fesr_state_t;

  typedef enum logic [1:0] {
    K_SUB4 = 2'b00,
    K_SUB32 = 2'b01,
    K_SECT = 2'b10,
    K_CHIP = 2'b11
  } fesr_kind_t;

endpackage : fesr_pkg

// file: rtl/fesr_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module fesr_sync #(
  parameter logic RST = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // level in and out
  input wire logic i_d,
  output logic o_q
);
  logic meta_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= RST;
      o_q <= RST;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : fesr_sync

// file: rtl/fesr_link.sv
// link side: captures opcode, address and byte count of one frame
`timescale 1ns/1ps
module fesr_link (
  // link clock and reset
  input wire logic i_sclk,
  input wire logic i_reset_n,
  // bus pins
  input wire logic i_cs_n,
  input wire logic [7:0] i_octal_data_lines,
  input wire logic i_octal_ddr,
  // frame, stable while chip select is high
  output logic [7:0] o_opcode,
  output logic [31:0] o_addr,
  output logic [7:0] o_nbytes,
  output logic o_ddr
);
  import fesr_pkg::*;

  logic ddr_s;
  logic frame_n;
  logic [7:0] rise_byte_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] op_nxt;
  logic [31:0] addr_nxt;
  logic [7:0] abeg;
  logic [7:0] aend;

  fesr_sync #(.RST(1'b0)) u_ddr_sync (
    .i_clk(i_sclk),
    .i_reset_n(i_reset_n),
    .i_d(i_octal_ddr),
    .o_q(ddr_s)
  );

  // count restarts with each frame; the clock stops between frames
  assign frame_n = i_reset_n & ~i_cs_n;
  // octal ddr carries a two-byte command, then a 4-byte address [RULE_13]
  assign abeg = ddr_s ? `FESR_CMD_DDR : `FESR_CMD_SDR;
  assign aend = abeg + `FESR_ADDR_LEN;

  // bytes are taken on the rising edge; in ddr the second byte of each pair is taken on the falling edge below [RULE_12]
  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rise_byte_r <= 8'h00;
    end else begin
      rise_byte_r <= i_octal_data_lines;
    end
  end

  // falling edge closes a byte, or in ddr a byte pair [RULE_13]
  always_comb begin
    op_nxt = o_opcode;
    addr_nxt = o_addr;
    cnt_nxt = cnt_r;
    if (cnt_r == 8'h00) begin
      op_nxt = rise_byte_r;
    end
    if (cnt_r >= abeg && cnt_r < aend) begin
      addr_nxt = {addr_nxt[23:0], rise_byte_r};
    end
    if (cnt_nxt != 8'hFF) begin
      cnt_nxt = cnt_nxt + 8'h01;
    end
    if (ddr_s) begin
      if (cnt_nxt >= abeg && cnt_nxt < aend) begin
        addr_nxt = {addr_nxt[23:0], i_octal_data_lines};
      end
      if (cnt_nxt != 8'hFF) begin
        cnt_nxt = cnt_nxt + 8'h01;
      end
    end
  end

  always_ff @(negedge i_sclk or negedge frame_n) begin
    if (!frame_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // frame results outlive chip select so the core can take them
  always_ff @(negedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_opcode <= 8'h00;
      o_addr <= 32'h00000000;
      o_nbytes <= 8'h00;
      o_ddr <= 1'b0;
    end else begin
      o_opcode <= op_nxt;
      o_addr <= addr_nxt;
      o_nbytes <= cnt_nxt;
      o_ddr <= ddr_s;
    end
  end
endmodule : fesr_link

// file: sim/fesr_host.sv
// far-side memory controller model driving the serial bus
`timescale 1ns/1ps
module fesr_host (
  // serial bus
  output logic o_sclk,
  output logic o_cs_n,
  output logic [7:0] o_dq
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq = 8'hA5;
  end
  // clock stands low between frames; the 7 ns offset keeps it unrelated to the core clock
  task automatic frame(input logic [39:0] b, input int n);
    logic [39:0] s;
    s = b;
    #7;
    o_cs_n = 1'b0;
    // bytes past the fifth go out as zero data bytes of a program
    for (int i = 0; i < n; i++) begin
      o_dq = s[39:32];
      s = s << 8;
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    // released lines show the inverse so a stale byte never reads as valid
    o_dq = ~o_dq;
    #200;
  endtask : frame
endmodule : fesr_host

// file: sim/test_flash_erase_suspend_resume_ctrl.sv
// self-checking bench of the erase, suspend and resume sequencer
`timescale 1ns/1ps
module test_flash_erase_suspend_resume_ctrl;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic sclk;
  logic cs_n;
  logic [7:0] dq;
  logic [63:0] lock = 64'h0;
  logic vfail = 1'b0;
  logic [5:0] rsec = 6'h00;
  logic ers_act;
  logic rd_ind;
  logic [1:0] ekind;
  logic o_wel;
  logic o_wip;
  logic [7:0] o_flag_status;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  always #10 i_mclk = ~i_mclk;
  fesr_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(dq));
  // shortened erase times keep the run brief, all above the suspend latency
  fesr_ctrl #(.SSE_CYC(3000), .SE_CYC(4000), .BE_CYC(5000), .PP_CYC(2000)) dut_u (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_octal_data_lines(dq), .i_octal_ddr(1'b0), .i_sector_lock(lock),
    .i_erase_verify_fail(vfail), .i_read_sector(rsec), .o_wel(o_wel), .o_wip(o_wip),
    .o_flag_status(o_flag_status), .o_erase_active(ers_act), .o_erase_base(), .o_erase_kind(ekind),
    .o_program_active(), .o_program_addr(), .o_read_indeterminate(rd_ind));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // compares {latch, busy, flag status}
  task automatic chk(input logic [9:0] exp);
    cmp({22'h000000, o_wel, o_wip, o_flag_status}, {22'h000000, exp});
  endtask : chk
  task automatic cmd(input logic [39:0] b, input int n, input int w, input logic [9:0] exp);
    host_u.frame(b, n);
    repeat (w) @(negedge i_mclk);
    chk(exp);
  endtask : cmd
  task automatic wait_idle();
    int k;
    k = 0;
    while (o_wip !== 1'b0 && k < 8000) begin
      @(negedge i_mclk);
      k++;
    end
  endtask : wait_idle
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    i_reset_n = 1'b1;
    @(negedge i_mclk);
    chk(10'h080);
    cmd(40'h2000012345, 5, 10, 10'h080);
    cmd(40'h7A00000000, 1, 10, 10'h080);
    cmd(40'h0600000000, 1, 10, 10'h280);
    lock[3] = 1'b1;
    cmd(40'hD800060000, 5, 10, 10'h2A2);
    cmd(40'h5000000000, 1, 10, 10'h280);
    for (int i = 0; i < 2; i++) begin
      cmd({(i == 0) ? 8'hC7 : 8'h60, 32'h0}, 1, 10, 10'h2A2);
      cmd(40'h5000000000, 1, 10, 10'h280);
    end
    lock[3] = 1'b0;
    cmd(40'h2000012345, 5, 10, 10'h300);
    cmd(40'h0400000000, 1, 10, 10'h300);
    // wait out the full suspend latency before trusting the ready bit
    cmd(40'h7500000000, 1, 1600, 10'h2C0);
    cmd(40'h7A00000000, 1, 10, 10'h300);
    wait_idle();
    chk(10'h080);
    cmd(40'h0600000000, 1, 10, 10'h280);
    vfail = 1'b1;
    cmd(40'hD8000A0000, 5, 10, 10'h300);
    wait_idle();
    chk(10'h0A0);
    vfail = 1'b0;
    // nested suspend: erase sector 5, program into it and beside it
    cmd(40'h5000000000, 1, 10, 10'h080);
    cmd(40'h0600000000, 1, 10, 10'h280);
    rsec = 6'h05;
    cmd(40'hD8000A0000, 5, 10, 10'h300);
    cmp({28'h0000000, ers_act, rd_ind, ekind}, 32'h0000000A);
    cmd(40'h7500000000, 1, 1600, 10'h2C0);
    cmp({30'h00000000, ers_act, rd_ind}, 32'h00000001);
    cmd(40'h02000A0100, 6, 10, 10'h2D0);
    cmd(40'h5000000000, 1, 10, 10'h2C0);
    cmd(40'h0200020000, 6, 10, 10'h340);
    cmd(40'h7500000000, 1, 1600, 10'h2C4);
    cmd(40'h7A00000000, 1, 10, 10'h340);
    wait_idle();
    chk(10'h0C0);
    cmd(40'h7A00000000, 1, 10, 10'h100);
    wait_idle();
    chk(10'h080);
    tally_and_finish();
  end
endmodule : test_flash_erase_suspend_resume_ctrl
